// file: hw/sgmm_device.sv
// Processor end: stop grant and management mode handshake
module sgmm_device (
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   rst_n,
    // Link
    sgmm_if.dev         link,
    // Core side
    input  wire logic   external_write_buffer_empty_mask,
    input  wire logic   core_bus_req,
    input  wire logic   mm_exit_req,
    input  wire logic   inquire_activity,
    output logic        mgmt_mode_active,
    output logic        core_running,
    output logic        instr_boundary
);
    //**********************************************************************
    // State decoding
    //**********************************************************************
    function automatic logic is_flush(input sgmm_pkg::sgmm_state_t s);
        return (s == sgmm_pkg::SGMM_SC_FLUSH) || (s == sgmm_pkg::SGMM_MM_FLUSH);
    endfunction

    function automatic logic is_issuing(input sgmm_pkg::sgmm_state_t s);
        return (s == sgmm_pkg::SGMM_RUN) || (s == sgmm_pkg::SGMM_MM_RUN);
    endfunction

    function automatic logic is_halted(input sgmm_pkg::sgmm_state_t s);
        return (s == sgmm_pkg::SGMM_HALTED) || (s == sgmm_pkg::SGMM_BCLK_OFF);
    endfunction

    function automatic logic is_mgmt_ack(input sgmm_pkg::sgmm_state_t s);
        return (s == sgmm_pkg::SGMM_MM_RUN) || (s == sgmm_pkg::SGMM_MM_EXIT);
    endfunction

    //**********************************************************************
    // Registers
    //**********************************************************************
    sgmm_pkg::sgmm_state_t state;
    sgmm_pkg::sgmm_state_t next_state;
    logic [3:0] outstanding;
    logic [1:0] flush_cnt;
    logic [1:0] bnd_cnt;
    logic       stop_sample;
    logic       smi_consume;
    logic       smi_pending;

    //**********************************************************************
    // Bus bookkeeping and boundary decode
    //**********************************************************************
    wire       burst_ready_in             = ~link.burst_ready_in_n;
    wire       external_write_buffer_empty_ok          = external_write_buffer_empty_mask | ~link.external_write_buffer_empty_n;
    wire       drained          = (outstanding == sgmm_pkg::SGMM_OUTSTAND_RESET);
    wire       last_rdy         = drained | ((outstanding == 4'h1) & burst_ready_in);
    wire       at_bound         = (bnd_cnt == sgmm_pkg::SGMM_BOUNDARY_DIV);
    wire       instr_boundary_n = ~at_bound;
    wire       can_issue        = is_issuing(state);
    wire       issue            = core_bus_req & can_issue & instr_boundary_n;
    wire       flushed          = (flush_cnt == sgmm_pkg::SGMM_FLUSH_CYCLES);
    wire       grant_now        = (state == sgmm_pkg::SGMM_SC_GRANT);
    wire [3:0] add              = {3'h0, issue | grant_now};
    wire [3:0] sub              = {3'h0, burst_ready_in & ~drained};

    //**********************************************************************
    // Next values
    //**********************************************************************
    wire [3:0] next_outstanding = outstanding + add - sub;
    wire [1:0] next_flush_cnt   = is_flush(state) ? flush_cnt + 2'h1 : 2'h0;
    wire [1:0] next_bnd_cnt     = bnd_cnt + 2'h1;
    wire       next_ack_n       = ~is_mgmt_ack(next_state);
    wire       next_halted      = is_halted(next_state);
    wire       next_running     = is_issuing(next_state);
    wire       next_mm_active   = (next_state == sgmm_pkg::SGMM_MM_RUN);

    //**********************************************************************
    // Management interrupt latch
    //**********************************************************************
    sgmm_edge_latch i_sgmm_edge_latch (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .req_n   (link.system_mgmt_interrupt_req_n),
        .consume (smi_consume),
        .pending (smi_pending)
    );

    assign smi_consume = at_bound & smi_pending & (state == sgmm_pkg::SGMM_RUN) & ~stop_sample;

    //**********************************************************************
    // Next state
    //**********************************************************************
    always_comb begin
        next_state = state;
        case (state)
            sgmm_pkg::SGMM_RUN: begin
                if (at_bound & stop_sample)
                    next_state = sgmm_pkg::SGMM_SC_FLUSH;
                else if (smi_consume)
                    next_state = sgmm_pkg::SGMM_MM_FLUSH;
            end
            sgmm_pkg::SGMM_SC_FLUSH: if (flushed) next_state = sgmm_pkg::SGMM_SC_DRAIN;
            sgmm_pkg::SGMM_SC_DRAIN: if (last_rdy) next_state = sgmm_pkg::SGMM_SC_GRANT;
            sgmm_pkg::SGMM_SC_GRANT: next_state = sgmm_pkg::SGMM_SC_WAIT;
            sgmm_pkg::SGMM_SC_WAIT: if (last_rdy & external_write_buffer_empty_ok) next_state = sgmm_pkg::SGMM_HALTED;
            sgmm_pkg::SGMM_HALTED: begin
                if (link.bus_clock_stopped)
                    next_state = sgmm_pkg::SGMM_BCLK_OFF;
                else if (link.stop_clock_request_n)
                    next_state = sgmm_pkg::SGMM_RUN;
            end
            sgmm_pkg::SGMM_BCLK_OFF: if (!link.bus_clock_stopped) next_state = sgmm_pkg::SGMM_HALTED;
            sgmm_pkg::SGMM_MM_FLUSH: if (flushed) next_state = sgmm_pkg::SGMM_MM_DRAIN;
            sgmm_pkg::SGMM_MM_DRAIN: if (last_rdy) next_state = sgmm_pkg::SGMM_MM_EXTERNAL_WRITE_BUFFER_EMPTY;
            sgmm_pkg::SGMM_MM_EXTERNAL_WRITE_BUFFER_EMPTY: if (external_write_buffer_empty_ok) next_state = sgmm_pkg::SGMM_MM_RUN;
            sgmm_pkg::SGMM_MM_RUN: if (mm_exit_req & ~inquire_activity) next_state = sgmm_pkg::SGMM_MM_EXIT;
            sgmm_pkg::SGMM_MM_EXIT: if (last_rdy) next_state = sgmm_pkg::SGMM_RUN;
            default: next_state = sgmm_pkg::SGMM_RUN;
        endcase
    end

    //**********************************************************************
    // State and counters
    //**********************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= sgmm_pkg::SGMM_RUN;
            outstanding <= sgmm_pkg::SGMM_OUTSTAND_RESET;
        end else begin
            state       <= next_state;
            outstanding <= next_outstanding;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flush_cnt <= 2'h0;
            bnd_cnt   <= 2'h0;
        end else begin
            flush_cnt <= next_flush_cnt;
            bnd_cnt   <= next_bnd_cnt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stop_sample <= 1'b0;
        end else begin
            stop_sample <= ~link.stop_clock_request_n;
        end
    end

    //**********************************************************************
    // Link outputs
    //**********************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.mgmt_mode_ack_n <= 1'b1;
        end else begin
            link.mgmt_mode_ack_n <= next_ack_n;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.stop_grant_cycle <= 1'b0;
        end else begin
            link.stop_grant_cycle <= grant_now;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.bus_cycle_start <= 1'b0;
        end else begin
            link.bus_cycle_start <= issue | grant_now;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.clock_halt_granted_state <= 1'b0;
        end else begin
            link.clock_halt_granted_state <= next_halted;
        end
    end

    //**********************************************************************
    // Core side outputs
    //**********************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_mode_active <= 1'b0;
        end else begin
            mgmt_mode_active <= next_mm_active;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_running <= 1'b1;
        end else begin
            core_running <= next_running;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            instr_boundary <= 1'b0;
        end else begin
            instr_boundary <= at_bound;
        end
    end
endmodule

// file: hw/sgmm_edge_latch.sv
// Falling edge latch for the management interrupt request
module sgmm_edge_latch (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Request pin and consume
    input  wire logic req_n,
    input  wire logic consume,
    // Pending flag
    output logic      pending
);
    logic prev_n;
    wire  fall = prev_n & ~req_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_n  <= 1'b1;
            pending <= 1'b0;
        end else begin
            prev_n  <= req_n;
            pending <= fall | (pending & ~consume);
        end
    end
endmodule

// file: hw/sgmm_if.sv
// Interface joining processor end and system logic end
interface sgmm_if;
    logic stop_clock_request_n;
    logic system_mgmt_interrupt_req_n;
    logic burst_ready_in_n;
    logic external_write_buffer_empty_n;
    logic mgmt_mode_ack_n;
    logic stop_grant_cycle;
    logic bus_cycle_start;
    logic bus_clock_stopped;
    logic clock_halt_granted_state;

    modport dev (
        input  stop_clock_request_n,
        input  system_mgmt_interrupt_req_n,
        input  burst_ready_in_n,
        input  external_write_buffer_empty_n,
        input  bus_clock_stopped,
        output mgmt_mode_ack_n,
        output stop_grant_cycle,
        output bus_cycle_start,
        output clock_halt_granted_state
    );
    modport sys (
        output stop_clock_request_n,
        output system_mgmt_interrupt_req_n,
        output burst_ready_in_n,
        output external_write_buffer_empty_n,
        output bus_clock_stopped,
        input  mgmt_mode_ack_n,
        input  stop_grant_cycle,
        input  bus_cycle_start,
        input  clock_halt_granted_state
    );
endinterface

// file: hw/sgmm_pkg.sv
// Package of constants and types for the stop grant and management mode handshake
//**********************************************************************
//**********************************************************************
package sgmm_pkg;
    // Core states
    typedef enum logic [3:0] {
        SGMM_RUN      = 4'h0,
        SGMM_SC_FLUSH = 4'h1,
        SGMM_SC_DRAIN = 4'h2,
        SGMM_SC_GRANT = 4'h3,
        SGMM_SC_WAIT  = 4'h4,
        SGMM_HALTED   = 4'h5,
        SGMM_BCLK_OFF = 4'h6,
        SGMM_MM_FLUSH = 4'h7,
        SGMM_MM_DRAIN = 4'h8,
        SGMM_MM_EXTERNAL_WRITE_BUFFER_EMPTY  = 4'h9,
        SGMM_MM_RUN   = 4'hA,
        SGMM_MM_EXIT  = 4'hB
    } sgmm_state_t;

    localparam logic [1:0] SGMM_FLUSH_CYCLES   = 2'h2;
    localparam logic [1:0] SGMM_BOUNDARY_DIV   = 2'h3;
    localparam logic [3:0] SGMM_OUTSTAND_RESET = 4'h0;
    localparam int         SGMM_ASYNC_HOLD     = 2;
    localparam logic [1:0] SGMM_HOST_HOLD      = 2'h2;
endpackage

// file: hw/sgmm_system.sv
// System logic end: drives requests and bus ready
module sgmm_system (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Link
    sgmm_if.sys       link,
    // User side
    input  wire logic user_stop_req,
    input  wire logic user_smi_req,
    input  wire logic user_wbuf_empty,
    input  wire logic user_stop_bclk,
    output logic      mm_memory_enable,
    output logic      stop_granted,
    output logic      cpu_halted
);
    logic       stop_hold;
    logic [1:0] hold_cnt;
    logic       burst_ready_in_pend;
    logic [1:0] grant_dly;

    wire granted = link.stop_grant_cycle;
    wire halted  = link.clock_halt_granted_state;
    // Grant cycle completes when its ready is returned, two clocks after the grant
    wire grant_done = grant_dly[1] & ~link.burst_ready_in_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stop_hold                          <= 1'b0;
            hold_cnt                           <= 2'h0;
            burst_ready_in_pend                          <= 1'b0;
            grant_dly                          <= 2'h0;
            link.stop_clock_request_n          <= 1'b1;
            link.system_mgmt_interrupt_req_n   <= 1'b1;
            link.burst_ready_in_n              <= 1'b1;
            link.external_write_buffer_empty_n <= 1'b1;
            link.bus_clock_stopped             <= 1'b0;
            mm_memory_enable                   <= 1'b0;
            stop_granted                       <= 1'b0;
            cpu_halted                         <= 1'b0;
        end else begin
            if (user_stop_req & ~stop_hold) begin
                stop_hold <= 1'b1;
                hold_cnt  <= 2'h0;
            end else if (stop_hold) begin
                if (hold_cnt != sgmm_pkg::SGMM_HOST_HOLD)
                    hold_cnt <= hold_cnt + 2'h1;
                if (!user_stop_req && hold_cnt == sgmm_pkg::SGMM_HOST_HOLD && (halted || stop_granted))
                    stop_hold <= 1'b0;
            end
            link.stop_clock_request_n          <= ~(stop_hold | user_stop_req);
            link.system_mgmt_interrupt_req_n   <= ~user_smi_req;
            burst_ready_in_pend                          <= link.bus_cycle_start;
            link.burst_ready_in_n              <= ~burst_ready_in_pend;
            link.external_write_buffer_empty_n <= ~user_wbuf_empty;
            link.bus_clock_stopped             <= user_stop_bclk & halted;
            mm_memory_enable                   <= ~link.mgmt_mode_ack_n;
            grant_dly                          <= {grant_dly[0], granted};
            stop_granted                       <= (stop_granted | grant_done) & stop_hold;
            cpu_halted                         <= halted;
        end
    end
endmodule

// file: tb/sgmm_monitor.sv
// Checker of the link between processor end and system logic end
module sgmm_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link signals
    input wire logic stop_clock_request_n,
    input wire logic system_mgmt_interrupt_req_n,
    input wire logic burst_ready_in_n,
    input wire logic external_write_buffer_empty_n,
    input wire logic mgmt_mode_ack_n,
    input wire logic stop_grant_cycle,
    input wire logic bus_cycle_start,
    input wire logic bus_clock_stopped,
    input wire logic clock_halt_granted_state
);
    timeunit 1ns / 100ps;
    logic [3:0] open_cyc;
    logic       smi_seen;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    //**********************************
    // Open bus cycles and pending request
    //**********************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            open_cyc <= 4'h0;
            smi_seen <= 1'b0;
        end else begin
            open_cyc <= open_cyc + {3'h0, bus_cycle_start} - {3'h0, !burst_ready_in_n};
            smi_seen <= (smi_seen | $fell(system_mgmt_interrupt_req_n)) & !$fell(mgmt_mode_ack_n);
        end
    end
    sequence s_grant_ready;
        stop_grant_cycle ##[1:4] !(burst_ready_in_n | external_write_buffer_empty_n | stop_clock_request_n);
    endsequence
    property p_ack_entry; $fell(mgmt_mode_ack_n) |-> open_cyc == 4'h0 && smi_seen; endproperty
    a_ack_entry: assert property (p_ack_entry) else $error("ack too early");
    property p_ack_exit; $rose(mgmt_mode_ack_n) |-> open_cyc == 4'h0; endproperty
    a_ack_exit: assert property (p_ack_exit) else $error("ack dropped early");
    property p_grant; stop_grant_cycle |-> open_cyc == 4'h0 && !stop_clock_request_n; endproperty
    a_grant: assert property (p_grant) else $error("grant before drain");
    property p_halt; s_grant_ready |-> ##[1:3] clock_halt_granted_state; endproperty
    a_halt: assert property (p_halt) else $error("no halt after grant");
    property p_halt_rise; $rose(clock_halt_granted_state) |-> open_cyc == 4'h0 && !$past(stop_clock_request_n); endproperty
    a_halt_rise: assert property (p_halt_rise) else $error("halt without drain");
    property p_hold; clock_halt_granted_state && !stop_clock_request_n && !bus_clock_stopped
        && !$past(bus_clock_stopped) |=> clock_halt_granted_state; endproperty
    a_hold: assert property (p_hold) else $error("halt lost");
    property p_restart; clock_halt_granted_state && !bus_clock_stopped && $rose(stop_clock_request_n)
        |-> ##[1:8] !clock_halt_granted_state; endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_bclk; $rose(bus_clock_stopped) |-> $past(clock_halt_granted_state); endproperty
    a_bclk: assert property (p_bclk) else $error("bus clock stopped early");
endmodule

// file: tb/sgmm_test.sv
// Self-checking bench of both handshake ends joined on one link
module sgmm_test;
    timeunit 1ns / 100ps;
    logic mclk, rst_n, external_write_buffer_empty_mask, core_bus_req, mm_exit_req, inquire_activity;
    logic grant_seen = 1'b0;
    logic user_stop_req, user_smi_req, user_wbuf_empty, user_stop_bclk;
    logic mgmt_mode_active, core_running, instr_boundary, mm_memory_enable, stop_granted, cpu_halted;
    int   n_mismatch, n_checks, nb;
    int   cyc = 0;
    sgmm_if link ();
    sgmm_device i_sgmm_device (.mclk, .rst_n, .link, .external_write_buffer_empty_mask, .core_bus_req, .mm_exit_req, .inquire_activity,
        .mgmt_mode_active, .core_running, .instr_boundary);
    sgmm_system i_sgmm_system (.mclk, .rst_n, .link, .user_stop_req, .user_smi_req, .user_wbuf_empty,
        .user_stop_bclk, .mm_memory_enable, .stop_granted, .cpu_halted);
    sgmm_monitor i_sgmm_monitor (.mclk, .rst_n, .stop_clock_request_n(link.stop_clock_request_n),
        .system_mgmt_interrupt_req_n(link.system_mgmt_interrupt_req_n), .burst_ready_in_n(link.burst_ready_in_n),
        .external_write_buffer_empty_n(link.external_write_buffer_empty_n), .mgmt_mode_ack_n(link.mgmt_mode_ack_n),
        .stop_grant_cycle(link.stop_grant_cycle), .bus_cycle_start(link.bus_cycle_start),
        .bus_clock_stopped(link.bus_clock_stopped), .clock_halt_granted_state(link.clock_halt_granted_state));
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (link.stop_grant_cycle === 1'b1) grant_seen <= 1'b1;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    //**********************************
    // Checks and drivers
    //**********************************
    task automatic chk(input string nm, input logic exp, input logic seen);
        n_checks++;
        if (seen !== exp) $display("[FAIL] %s expected %b seen %b", nm, exp, seen);
        if (seen !== exp) n_mismatch++;
    endtask
    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 300 && s !== v; i++) @(negedge mclk);
    endtask
    task automatic traffic();
        repeat ($urandom_range(3, 12)) @(negedge mclk) core_bus_req = 1'($urandom_range(0, 1));
        @(negedge mclk) core_bus_req = 1'b0;
    endtask
    function automatic logic ack_due(input logic mask, input logic empty);
        return mask | empty;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {mclk, rst_n, external_write_buffer_empty_mask, core_bus_req, mm_exit_req, inquire_activity} = '0;
        {user_stop_req, user_smi_req, user_wbuf_empty, user_stop_bclk} = '0;
        {n_mismatch, n_checks, nb} = '0;
        void'($urandom(32'h8774A73A));
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        chk("ack after reset", 1'b1, link.mgmt_mode_ack_n);
        chk("halt after reset", 1'b0, link.clock_halt_granted_state);
        repeat (16) @(negedge mclk) nb += int'(instr_boundary);
        chk("boundary rate", 1'b1, nb == 16 / (sgmm_pkg::SGMM_BOUNDARY_DIV + 1));
        $display("test reset done");
        traffic();
        {user_wbuf_empty, user_stop_req} = 2'h3;
        wait_lvl(link.clock_halt_granted_state, 1'b1);
        chk("halted", 1'b1, link.clock_halt_granted_state);
        chk("grant cycle", 1'b1, grant_seen);
        chk("stop granted", 1'b1, stop_granted);
        user_stop_bclk = 1'b1;
        wait_lvl(link.bus_clock_stopped, 1'b1);
        chk("bus clock stopped", 1'b1, link.bus_clock_stopped);
        chk("cpu halted", 1'b1, cpu_halted);
        user_stop_bclk = 1'b0;
        repeat (4) @(negedge mclk);
        user_stop_req = 1'b0;
        wait_lvl(link.clock_halt_granted_state, 1'b0);
        repeat (2) @(negedge mclk);
        chk("core running", 1'b1, core_running);
        $display("test stop clock done");
        for (int k = 0; k < 4; k++) begin
            external_write_buffer_empty_mask = k[0];
            user_wbuf_empty = k[1];
            traffic();
            user_smi_req = 1'b1;
            repeat (3) @(negedge mclk);
            user_smi_req = 1'b0;
            repeat (30) @(negedge mclk);
            chk("ack entry", !ack_due(k[0], k[1]), link.mgmt_mode_ack_n);
            user_wbuf_empty = 1'b1;
            wait_lvl(link.mgmt_mode_ack_n, 1'b0);
            @(negedge mclk);
            chk("memory enable", 1'b1, mm_memory_enable);
            chk("mgmt mode active", 1'b1, mgmt_mode_active);
            {inquire_activity, mm_exit_req} = 2'h3;
            repeat (8) @(negedge mclk);
            chk("ack during snoop", 1'b0, link.mgmt_mode_ack_n);
            inquire_activity = 1'b0;
            wait_lvl(link.mgmt_mode_ack_n, 1'b1);
            chk("ack after exit", 1'b1, link.mgmt_mode_ack_n);
            mm_exit_req = 1'b0;
            $display("test management mode %0d done", k);
        end
        close_out();
    end
endmodule
